// file: verilog/mce_pkg.sv
`default_nettype none

package mce_pkg;
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 6;
    localparam logic [11:0] RESET_PC = 12'h000;
    localparam logic [11:0] INT_VECTOR = 12'h004;
    localparam logic [7:0] SD_BASE = 8'h80;
    localparam logic [7:0] ACC_ADDR = 8'hff;
    localparam logic [2:0] CYC_SHORT = 3'h2;
    localparam logic [2:0] CYC_STD = 3'h4;
    localparam logic [2:0] CYC_BTST = 3'h5;
    localparam logic [2:0] STEP_OPND = 3'h2;
    localparam logic [3:0] LOW_CALL = 4'h1;
    localparam logic [3:0] LOW_JP = 4'h9;
    localparam logic [3:0] LOW_BTST = 4'h3;
    localparam logic [3:0] LOW_BIT = 4'hb;
    localparam logic [3:0] LOW_SD = 4'h5;
    localparam logic [3:0] LOW_IND = 4'h7;
    localparam logic [3:0] LOW_MEM = 4'hf;

    typedef enum logic [3:0] {
        K_BR, K_CALL, K_JP, K_BTST, K_BIT, K_SD, K_IND, K_DIR, K_IMM, K_INH
    } mce_kind_t;
    typedef enum logic [2:0] {
        ALU_LD, ALU_CP, ALU_ADD, ALU_INC, ALU_AND, ALU_SUB, ALU_DEC, ALU_ST
    } mce_alu_t;
    typedef enum logic [3:0] {
        INH_NOP, INH_RET, INH_INTERRUPT_RETURN, INH_STOP, INH_WAIT,
        INH_COM, INH_RLC, INH_SLA, INH_CLRA
    } mce_inh_t;
    typedef enum logic [1:0] {SD_INC, SD_LDA, SD_DEC, SD_STA} mce_sdfn_t;
    typedef struct packed {
        mce_kind_t kind;
        logic [2:0] cycles;
        logic [1:0] len;
    } mce_dec_t;
    typedef struct packed {
        logic [7:0] addr;
        logic we;
        logic [7:0] wdata;
    } mce_dm_req_t;
    typedef logic [STACK_DEPTH-1:0][11:0] mce_stack_t;

    function automatic mce_dec_t mce_decode(input logic [7:0] op);
        mce_dec_t d;
        d.kind = K_INH;
        d.cycles = CYC_STD;
        d.len = 2'h1;
        if (!op[0]) begin
            d.kind = K_BR;
            d.cycles = CYC_SHORT;
        end else begin
            case (op[3:0])
                LOW_CALL: begin
                    d.kind = K_CALL;
                    d.len = 2'h2;
                end
                LOW_JP: begin
                    d.kind = K_JP;
                    d.len = 2'h2;
                end
                LOW_BTST: begin
                    d.kind = K_BTST;
                    d.len = 2'h3;
                    d.cycles = CYC_BTST;
                end
                LOW_BIT: begin
                    d.kind = K_BIT;
                    d.len = 2'h2;
                end
                LOW_SD: d.kind = K_SD;
                LOW_IND: d.kind = K_IND;
                LOW_MEM: begin
                    d.kind = op[4] ? K_IMM : K_DIR;
                    d.len = (op[4] && (op[7:5] == 3'h3 || op[7:5] == 3'h6))
                        ? 2'h3 : 2'h2;
                end
                default: begin
                    case (op[7:4])
                        4'h5, 4'h6: d.cycles = CYC_STD;
                        4'h7, 4'h8: d.len = 2'h2;
                        default: d.cycles = CYC_SHORT;
                    endcase
                end
            endcase
        end
        return d;
    endfunction
endpackage

`default_nettype wire

// file: verilog/mce_sync3.sv
`default_nettype none

module mce_sync3 #(
    parameter int WIDTH = 2
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [WIDTH-1:0] s1_next, s2_next, s3_next, out_next;

    // A bit changes only once the second and third stages agree.
    always_comb begin
        s1_next = async_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
        out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule

`default_nettype wire

// file: verilog/mce_core.sv
// Function
// - Forty instruction types in six groups over nine addressing modes.
// - Loads and stores take one to three bytes; accumulator and memory.
// - Load-immediate writes a program constant into any data location.
// - Load-immediate-to-register: three bytes, four cycles, flags kept.
// - Add, and, compare, subtract use accumulator plus memory or immediate.
// - Clear, decrement, increment reach any address; complement, rotate, shift the accumulator.
// - Direct add, subtract, compare: two bytes, four cycles, zero and carry updated.
// - Relative branches jump only when their carry or zero condition holds.
// - Short branch reach is minus fifteen to plus sixteen.
// - Bit-test branch reach is minus 126 to plus 129.
// - Bit set and clear reach any data bit; two bytes, four cycles.
// - Control instructions: one byte, two cycles; only interrupt return changes flags.
// - With watchdog selected, stop behaves as wait.
// - Jump and call use a twelve-bit absolute target.
// - Two pointer registers give indirect addresses; others only short direct.
// - Short branch direction bit: zero forward, one backward; four-bit span.
// - Short registers at 80h..83h; opcode bit 4 picks the pointer.
`default_nettype none

module mce_core (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [7:0] pm_data_in,
    input wire logic [7:0] dm_rdata_in,
    input wire logic watchdog_sel_in,
    input wire logic int_req_in,
    output logic [mce_pkg::PC_W-1:0] pm_addr_out,
    output var mce_pkg::mce_dm_req_t dm_req_out,
    output logic [7:0] acc_out,
    output logic zero_out,
    output logic carry_out,
    output logic wait_out,
    output logic stop_out,
    output logic instr_done_out
);
    import mce_pkg::*;

    logic [11:0] pc_reg, pc_next, pm_addr_reg, pm_addr_next;
    logic [2:0] step_reg, step_next;
    logic [7:0] op_reg, op_next, b1_reg, b1_next, b2_reg, b2_next;
    logic [7:0] opnd_reg, opnd_next, acc_reg, acc_next;
    logic z_reg, z_next, c_reg, c_next, zs_reg, zs_next, cs_reg, cs_next;
    logic in_int_reg, in_int_next, wait_reg, wait_next;
    logic stop_reg, stop_next, done_reg, done_next;
    mce_dm_req_t dm_reg, dm_next;
    mce_stack_t stack_reg, stack_next;

    logic [1:0] pin_s;
    mce_dec_t dec_now, dec_cur;
    logic run, start, last_step, int_take, wr, z_n, c_n, sel, bit_v;
    logic [11:0] npc;
    logic [7:0] res, src, a_n;
    logic [8:0] sum9;
    mce_alu_t alu;

    mce_sync3 #(.WIDTH(2)) u_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in({int_req_in, watchdog_sel_in}),
        .sync_out(pin_s)
    );

    assign dec_now = mce_decode(pm_data_in);
    assign dec_cur = mce_decode(op_reg);
    assign run = !(wait_reg || stop_reg);
    assign start = run && step_reg == 3'h0;
    assign last_step = run && step_reg != 3'h0
        && step_reg == dec_cur.cycles - 3'h1;
    assign int_take = pin_s[1] && !in_int_reg;

    always_comb begin
        pc_next = pc_reg;
        pm_addr_next = pm_addr_reg;
        step_next = step_reg;
        op_next = op_reg;
        b1_next = b1_reg;
        b2_next = b2_reg;
        opnd_next = opnd_reg;
        acc_next = acc_reg;
        z_next = z_reg;
        c_next = c_reg;
        zs_next = zs_reg;
        cs_next = cs_reg;
        in_int_next = in_int_reg;
        wait_next = wait_reg;
        stop_next = stop_reg;
        done_next = 1'b0;
        dm_next = dm_reg;
        dm_next.we = 1'b0;
        stack_next = stack_reg;
        npc = pc_reg;
        res = opnd_reg;
        src = opnd_reg;
        a_n = acc_reg;
        z_n = z_reg;
        c_n = c_reg;
        wr = 1'b0;
        sel = 1'b0;
        bit_v = 1'b0;
        sum9 = 9'h000;
        alu = mce_alu_t'(op_reg[7:5]);
        if (!run) begin
            if (int_take) begin
                stack_next = {stack_reg[STACK_DEPTH-2:0], pc_reg};
                zs_next = z_reg;
                cs_next = c_reg;
                in_int_next = 1'b1;
                wait_next = 1'b0;
                stop_next = 1'b0;
                pc_next = INT_VECTOR;
                pm_addr_next = INT_VECTOR;
            end
        end else if (step_reg == 3'h0) begin
            op_next = pm_data_in;
            pm_addr_next = pc_reg + 12'h001;
            step_next = 3'h1;
            if (dec_now.kind == K_SD) begin
                dm_next.addr = SD_BASE + {6'h00, pm_data_in[7:6]};
            end else if (dec_now.kind == K_IND) begin
                dm_next.addr = SD_BASE + {7'h00, pm_data_in[4]};
            end
        end else begin
            step_next = step_reg + 3'h1;
            if (step_reg == 3'h1) begin
                b1_next = pm_data_in;
                pm_addr_next = pc_reg + 12'h002;
                if (dec_cur.kind == K_IND) begin
                    dm_next.addr = dm_rdata_in;
                end else if (dec_cur.kind == K_DIR || dec_cur.kind == K_BIT
                    || dec_cur.kind == K_BTST
                    || (dec_cur.kind == K_IMM && dec_cur.len == 2'h3)) begin
                    dm_next.addr = pm_data_in;
                end
            end
            if (step_reg == STEP_OPND) begin
                b2_next = pm_data_in;
                // The accumulator is also visible in data space.
                opnd_next = (dm_reg.addr == ACC_ADDR) ? acc_reg : dm_rdata_in;
            end
            if (last_step) begin
                done_next = 1'b1;
                step_next = 3'h0;
                npc = pc_reg + {10'h000, dec_cur.len};
                case (dec_cur.kind)
                    K_BR: begin
                        sel = op_reg[1] ? c_reg : z_reg;
                        if (sel == op_reg[2]) begin
                            npc = op_reg[3]
                                ? pc_reg - {8'h00, op_reg[7:4]}
                                : pc_reg + 12'h001 + {8'h00, op_reg[7:4]};
                        end
                    end
                    K_CALL: begin
                        stack_next = {stack_reg[STACK_DEPTH-2:0], npc};
                        npc = {op_reg[7:4], b1_reg};
                    end
                    K_JP: npc = {op_reg[7:4], b1_reg};
                    K_BTST: begin
                        bit_v = opnd_reg[op_reg[7:5]];
                        c_n = bit_v;
                        if (bit_v == op_reg[4]) begin
                            npc = pc_reg + 12'h002
                                + {{4{b2_reg[7]}}, b2_reg};
                        end
                    end
                    K_BIT: begin
                        res[op_reg[7:5]] = op_reg[4];
                        wr = 1'b1;
                    end
                    K_SD: begin
                        case (mce_sdfn_t'(op_reg[5:4]))
                            SD_INC: res = opnd_reg + 8'h01;
                            SD_DEC: res = opnd_reg - 8'h01;
                            SD_LDA: a_n = opnd_reg;
                            SD_STA: res = acc_reg;
                            default: res = opnd_reg;
                        endcase
                        wr = op_reg[5:4] != 2'h1;
                        z_n = (wr ? res : a_n) == 8'h00;
                    end
                    K_IND, K_DIR, K_IMM: begin
                        if (dec_cur.kind == K_IMM) begin
                            src = (dec_cur.len == 2'h3) ? b2_reg : b1_reg;
                        end
                        if (dec_cur.kind == K_IMM && alu == ALU_INC) begin
                            res = b2_reg;
                            wr = 1'b1;
                        end else if (dec_cur.kind == K_IMM && alu == ALU_DEC) begin
                            res = 8'h00;
                            wr = 1'b1;
                        end else if (dec_cur.kind == K_IMM && alu == ALU_ST) begin
                            res = opnd_reg;
                        end else begin
                            case (alu)
                                ALU_LD: begin
                                    a_n = src;
                                    z_n = src == 8'h00;
                                end
                                ALU_CP: begin
                                    sum9 = {1'b0, acc_reg} - {1'b0, src};
                                    z_n = sum9[7:0] == 8'h00;
                                    c_n = sum9[8];
                                end
                                ALU_ADD: begin
                                    sum9 = {1'b0, acc_reg} + {1'b0, src};
                                    a_n = sum9[7:0];
                                    z_n = sum9[7:0] == 8'h00;
                                    c_n = sum9[8];
                                end
                                ALU_SUB: begin
                                    sum9 = {1'b0, acc_reg} - {1'b0, src};
                                    a_n = sum9[7:0];
                                    z_n = sum9[7:0] == 8'h00;
                                    c_n = sum9[8];
                                end
                                ALU_AND: begin
                                    a_n = acc_reg & src;
                                    z_n = (acc_reg & src) == 8'h00;
                                end
                                ALU_INC, ALU_DEC: begin
                                    res = (alu == ALU_INC) ? src + 8'h01
                                        : src - 8'h01;
                                    z_n = res == 8'h00;
                                    wr = 1'b1;
                                end
                                ALU_ST: begin
                                    res = acc_reg;
                                    z_n = acc_reg == 8'h00;
                                    wr = 1'b1;
                                end
                                default: res = opnd_reg;
                            endcase
                        end
                    end
                    default: begin
                        case (mce_inh_t'(op_reg[7:4]))
                            INH_RET: begin
                                npc = stack_reg[0];
                                stack_next = {stack_reg[STACK_DEPTH-1],
                                    stack_reg[STACK_DEPTH-1:1]};
                            end
                            INH_INTERRUPT_RETURN: begin
                                npc = stack_reg[0];
                                stack_next = {stack_reg[STACK_DEPTH-1],
                                    stack_reg[STACK_DEPTH-1:1]};
                                z_n = zs_reg;
                                c_n = cs_reg;
                                in_int_next = 1'b0;
                            end
                            INH_STOP: begin
                                wait_next = pin_s[0];
                                stop_next = !pin_s[0];
                            end
                            INH_WAIT: wait_next = 1'b1;
                            INH_COM: begin
                                a_n = ~acc_reg;
                                c_n = acc_reg[7];
                                z_n = acc_reg == 8'hff;
                            end
                            INH_RLC: begin
                                {c_n, a_n} = {acc_reg, c_reg};
                                z_n = {acc_reg[6:0], c_reg} == 8'h00;
                            end
                            INH_SLA: begin
                                {c_n, a_n} = {acc_reg, 1'b0};
                                z_n = acc_reg[6:0] == 7'h00;
                            end
                            INH_CLRA: begin
                                a_n = 8'h00;
                                z_n = 1'b1;
                                c_n = 1'b0;
                            end
                            default: npc = npc;
                        endcase
                    end
                endcase
                if (wr) begin
                    if (dm_reg.addr == ACC_ADDR) begin
                        a_n = res;
                    end else begin
                        dm_next.we = 1'b1;
                        dm_next.wdata = res;
                    end
                end
                acc_next = a_n;
                z_next = z_n;
                c_next = c_n;
                pc_next = npc;
                pm_addr_next = npc;
                if (int_take) begin
                    stack_next = {stack_next[STACK_DEPTH-2:0], npc};
                    zs_next = z_n;
                    cs_next = c_n;
                    in_int_next = 1'b1;
                    wait_next = 1'b0;
                    stop_next = 1'b0;
                    pc_next = INT_VECTOR;
                    pm_addr_next = INT_VECTOR;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            pc_reg <= RESET_PC;
            pm_addr_reg <= RESET_PC;
            step_reg <= 3'h0;
            op_reg <= 8'h00;
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            opnd_reg <= 8'h00;
            acc_reg <= 8'h00;
            z_reg <= 1'b0;
            c_reg <= 1'b0;
            zs_reg <= 1'b0;
            cs_reg <= 1'b0;
            in_int_reg <= 1'b0;
            wait_reg <= 1'b0;
            stop_reg <= 1'b0;
            done_reg <= 1'b0;
            dm_reg <= '0;
            stack_reg <= '0;
        end else begin
            pc_reg <= pc_next;
            pm_addr_reg <= pm_addr_next;
            step_reg <= step_next;
            op_reg <= op_next;
            b1_reg <= b1_next;
            b2_reg <= b2_next;
            opnd_reg <= opnd_next;
            acc_reg <= acc_next;
            z_reg <= z_next;
            c_reg <= c_next;
            zs_reg <= zs_next;
            cs_reg <= cs_next;
            in_int_reg <= in_int_next;
            wait_reg <= wait_next;
            stop_reg <= stop_next;
            done_reg <= done_next;
            dm_reg <= dm_next;
            stack_reg <= stack_next;
        end
    end

    assign pm_addr_out = pm_addr_reg;
    assign dm_req_out = dm_reg;
    assign acc_out = acc_reg;
    assign zero_out = z_reg;
    assign carry_out = c_reg;
    assign wait_out = wait_reg;
    assign stop_out = stop_reg;
    assign instr_done_out = done_reg;

    a_branch_cycles: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        start && dec_now.kind == K_BR |-> ##1 !instr_done_out ##1 instr_done_out)
        else $error("flag branch not done in two cycles");
    a_btst_cycles: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        start && dec_now.kind == K_BTST
        |-> ##1 (!instr_done_out) [*4] ##1 instr_done_out)
        else $error("bit test branch not done in five cycles");
    a_bit_cycles: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        start && dec_now.kind == K_BIT |-> ##4 instr_done_out
        && $stable(zero_out) && $stable(carry_out))
        else $error("bit set or clear timing or flags wrong");
    a_jump_target: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        last_step && dec_cur.kind == K_JP && !int_take
        |=> pm_addr_out == {$past(op_reg[7:4]), $past(b1_reg)})
        else $error("jump target wrong");
    a_branch_untaken: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        last_step && dec_cur.kind == K_BR && !int_take
        && (op_reg[1] ? c_reg : z_reg) != op_reg[2]
        |=> pm_addr_out == $past(pc_reg) + 12'h001)
        else $error("untaken branch did not fall through");
    a_ldi_flags: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        last_step && dec_cur.kind == K_IMM && op_reg[7:5] == 3'h3
        |=> zero_out == $past(zero_out) && carry_out == $past(carry_out))
        else $error("load immediate changed flags");
    a_incdec_carry: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        last_step && dec_cur.kind == K_DIR
        && (op_reg[7:5] == 3'h3 || op_reg[7:5] == 3'h6)
        |=> carry_out == $past(carry_out) && zero_out == $past(res == 8'h00))
        else $error("increment or decrement flags wrong");
    a_add_zero: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        last_step && dec_cur.kind == K_DIR && op_reg[7:5] == 3'h2
        |=> zero_out == (acc_out == 8'h00))
        else $error("add zero flag disagrees with accumulator");
    a_stop_as_wait: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        last_step && dec_cur.kind == K_INH && op_reg[7:4] == 4'h3
        && pin_s[0] && !int_take |=> wait_out && !stop_out)
        else $error("stop not replaced by wait");
    a_short_addr: assert property (
        @(posedge clock_in) disable iff (!resetn_in)
        start && dec_now.kind == K_IND
        |=> dm_req_out.addr == SD_BASE + {7'h00, $past(pm_data_in[4])})
        else $error("pointer register address wrong");
endmodule

`default_nettype wire

// file: test/mce_mem_model.sv
`default_nettype none

module mce_mem_model (
    input wire logic clock_in,
    input wire logic [11:0] pm_addr_in,
    output logic [7:0] pm_data_out,
    input wire mce_pkg::mce_dm_req_t dm_req_in,
    output logic [7:0] dm_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import mce_pkg::*;
    logic [7:0] rom [4096];
    logic [7:0] ram [256];
    assign pm_data_out = rom[pm_addr_in];
    assign dm_rdata_out = ram[dm_req_in.addr];
    always @(posedge clock_in) begin
        if (dm_req_in.we)
            ram[dm_req_in.addr] <= dm_req_in.wdata;
    end
endmodule

`default_nettype wire

// file: test/mcu_core_instruction_execution_bench.sv
`default_nettype none

module mcu_core_instruction_execution_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mce_pkg::*;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic wd = 1'b0;
    logic [11:0] pa;
    logic [7:0] pd, rd, acc;
    mce_dm_req_t dq;
    logic z, c, wt, st, done;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int dt[$];
    mce_core i_mce_core (.clock_in(clock_in), .resetn_in(resetn_in),
        .pm_data_in(pd), .dm_rdata_in(rd), .watchdog_sel_in(wd),
        .int_req_in(1'b0), .pm_addr_out(pa), .dm_req_out(dq),
        .acc_out(acc), .zero_out(z), .carry_out(c), .wait_out(wt),
        .stop_out(st), .instr_done_out(done));
    mce_mem_model i_mce_mem_model (.clock_in(clock_in), .pm_addr_in(pa),
        .pm_data_out(pd), .dm_req_in(dq), .dm_rdata_out(rd));
    initial begin
        forever #10 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc++;
        if (done === 1'b1)
            dt.push_back(cyc);
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict;
        end
    end
    task print_verdict;
        $display("checked=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task load(input int a, input logic [7:0] b[$]);
        foreach (b[i])
            i_mce_mem_model.rom[a+i] = b[i];
    endtask
    // Resets the core, then lets it run until n instructions completed.
    task run(input int n);
        int k;
        @(posedge clock_in);
        #1 resetn_in = 1'b0;
        repeat (4) @(posedge clock_in);
        dt = {};
        #1 resetn_in = 1'b1;
        for (k = 0; k < 200 && dt.size() < n; k++)
            @(posedge clock_in);
        repeat (6) @(posedge clock_in);
        #1;
    endtask
    task test_alu_seq;
        foreach (i_mce_mem_model.rom[i])
            i_mce_mem_model.rom[i] = 8'h0d;
        i_mce_mem_model.ram[8'h10] = 8'h20;
        i_mce_mem_model.ram[8'h21] = 8'h01;
        load(0, '{8'h1f, 8'hf0, 8'h4f, 8'h10, 8'h7f, 8'h20, 8'h00,
            8'h6f, 8'h20, 8'hfb, 8'h21});
        run(6);
        chk(acc, 8'h10);
        chk({6'h0, z, c}, 8'h01);
        chk(i_mce_mem_model.ram[8'h20], 8'h01);
        chk(i_mce_mem_model.ram[8'h21], 8'h81);
        chk(8'(dt[4] - dt[0]), 8'h10);
    endtask
    task test_branch;
        load(0, '{8'h3f, 8'h01, 8'hf6, 8'h1f, 8'h11});
        load(8'h12, '{8'h1f, 8'h5a});
        run(3);
        chk(acc, 8'h5a);
        chk(8'(dt[1] - dt[0]), 8'h02);
        chk({6'h0, z, c}, 8'h01);
    endtask
    // Jump, call, return, bit test branch, short direct and indirect.
    task test_jump;
        i_mce_mem_model.ram[8'h30] = 8'h01;
        load(0, '{8'h09, 8'h10});
        load(8'h10, '{8'h01, 8'h20, 8'h13, 8'h30, 8'h04});
        load(8'h18, '{8'h1f, 8'h30, 8'h35, 8'h07});
        load(8'h20, '{8'h1d});
        run(7);
        chk(acc, 8'h01);
        chk(i_mce_mem_model.ram[8'h80], 8'h30);
        chk({6'h0, z, c}, 8'h01);
        chk(8'(dt[1] - dt[0]), 8'h04);
        chk(8'(dt[3] - dt[2]), 8'h05);
    endtask
    task test_halt;
        logic [8:0] tb[3];
        tb = '{9'h03d, 9'h13d, 9'h04d};
        foreach (tb[i]) begin
            wd = tb[i][8];
            // Two leading no-ops let the option pin clear its synchroniser.
            load(0, '{8'h0d, 8'h0d, tb[i][7:0]});
            run(3);
            chk({6'h0, wt, st}, (tb[i] == 9'h03d) ? 8'h01 : 8'h02);
        end
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        test_alu_seq;
        test_branch;
        test_jump;
        test_halt;
        print_verdict;
    end
endmodule

`default_nettype wire
